// ===== common/clock_gate_map.vh
// offsets, field positions and reset values of the clock gate bank
// assumes a 32-bit register bus decoding a 12-bit byte offset
`ifndef CLOCK_GATE_MAP_VH
`define CLOCK_GATE_MAP_VH

// ------------------------------------------------------------
// addressing
// ------------------------------------------------------------
`define CG_BASE_ADDR 32'h400fe000
`define CG_ADDR_W 12
`define CG_OFS_RUN_CFG 12'h060
`define CG_OFS_RUN_GATE 12'h108
`define CG_OFS_SLEEP_GATE 12'h118
`define CG_OFS_DEEP_GATE 12'h128
`define CG_OFS_IRQ_STATUS 12'h150
`define CG_OFS_IRQ_MASK 12'h154
`define CG_OFS_APPLIED 12'h158

// ------------------------------------------------------------
// gate register layout
// ------------------------------------------------------------
`define CG_GATE_RESET 32'h00000000
`define CG_GATE_WR_MASK 32'h5000007f
`define CG_PHY_BIT 30
`define CG_MAC_BIT 28
`define CG_PORT_MSB 6
`define CG_PORT_LSB 0
`define CG_UNITS 9

// ------------------------------------------------------------
// run clock configuration and interrupt layout
// ------------------------------------------------------------
`define CG_AUTO_GATE_BIT 27
`define CG_CFG_WR_MASK 32'h08000000
`define CG_IRQ_WR_MASK 32'h00000007
`define CG_EVT_FAULT 0
`define CG_EVT_SLEEP 1
`define CG_EVT_DEEP 2
`define CG_MODE_SLEEP_BIT 16
`define CG_MODE_DEEP_BIT 17

// ------------------------------------------------------------
// bus answers
// ------------------------------------------------------------
`define CG_RESP_OKAY 2'h0
`define CG_RESP_SLVERR 2'h2

`endif

// ===== verilog/gate_reg_word.v
// one software-writable 32-bit register with byte enables
// assumes writes are single-cycle strobes already qualified by the bus
`timescale 1ns/1ps
module gate_reg_word #(
    parameter [31:0] WR_MASK = 32'hffffffff,
    parameter [31:0] RESET_VALUE = 32'h00000000
) (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire ce_in,
    input wire wr_in,
    input wire [31:0] data_in,
    input wire [3:0] be_in,
    output wire [31:0] q_out
);
    reg [31:0] word_q;
    reg [31:0] word_d;
    integer i;

    // byte lanes merge; bits outside the mask stay at reset value
    always @* begin
        word_d = word_q;
        for (i = 0; i < 4; i = i + 1) begin
            if (be_in[i]) begin
                word_d[i*8 +: 8] = data_in[i*8 +: 8];
            end
        end
        word_d = (word_d & WR_MASK) | (RESET_VALUE & ~WR_MASK);
    end

    // storage
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            word_q <= RESET_VALUE;
        end else if (ce_in && wr_in) begin
            word_q <= word_d;
        end
    end

    assign q_out = word_q;
endmodule // gate_reg_word

// ===== verilog/unit_access_guard.v
// bus-fault answer for one gated unit
// assumes the unit select is a level held by the system bus for the access
`timescale 1ns/1ps
module unit_access_guard (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire ce_in,
    input wire access_in,
    input wire clock_enable_in,
    output wire fault_out
);
    reg fault_q;

    // an access to an unclocked unit becomes a fault one cycle later
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fault_q <= 1'b0;
        end else if (ce_in) begin
            fault_q <= access_in & ~clock_enable_in;
        end
    end

    assign fault_out = fault_q;
endmodule // unit_access_guard

// ===== verilog/deep_sleep_clock_gate_bank.v
// clock gate bank: run, sleep and deep-sleep enables for nine units
// assumes an avalon-mm master with waitrequest and synchronous inputs
`timescale 1ns/1ps
`include "clock_gate_map.vh"

module deep_sleep_clock_gate_bank (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire ce_in,
    // avalon-mm slave
    input wire [11:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output wire avs_waitrequest_out,
    output wire [31:0] avs_readdata_out,
    output wire [1:0] avs_response_out,
    // power state of the system
    input wire sleep_in,
    input wire deep_sleep_in,
    // unit accesses and answers, index 0..6 ports a..g, 7 mac, 8 phy
    input wire [8:0] unit_access_in,
    output wire [8:0] unit_fault_out,
    output wire [8:0] unit_clock_enable_out,
    // interrupt
    output wire irq_out
);

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    wire ack;
    reg [31:0] rdata_q;
    reg [1:0] resp_q;
    wire req;
    wire accept;
    wire wr_stb;

    assign req = avs_read_in | avs_write_in;
    // one wait cycle, then the request is taken at the next edge
    assign avs_waitrequest_out = req & ~(ack & ce_in);
    assign accept = req & ack & ce_in;
    assign wr_stb = avs_write_in & accept;

    // one-hot handshake: a request waits one cycle, then is answered
    localparam [1:0] HS_IDLE = 2'b01;
    localparam [1:0] HS_ANSWER = 2'b10;
    reg [1:0] hs_q;
    reg [1:0] hs_d;

    // next handshake state; the answer never lasts past one cycle
    always @* begin
        case (hs_q)
            HS_IDLE: begin
                hs_d = req ? HS_ANSWER : HS_IDLE;
            end
            HS_ANSWER: begin
                hs_d = HS_IDLE;
            end
            default: begin
                hs_d = HS_IDLE;
            end
        endcase
    end

    // handshake state, frozen while the clock enable is low
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hs_q <= HS_IDLE;
        end else if (ce_in) begin
            hs_q <= hs_d;
        end
    end

    // ack marks the single cycle in which the answer stands
    assign ack = (hs_q == HS_ANSWER);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire hit_cfg;
    wire hit_run;
    wire hit_sleep;
    wire hit_deep;
    wire hit_stat;
    wire hit_mask;
    wire hit_appl;
    wire hit_any;

    // exact decode of the full byte offset, low two bits included
    assign hit_cfg = (avs_address_in == `CG_OFS_RUN_CFG);
    assign hit_run = (avs_address_in == `CG_OFS_RUN_GATE);
    assign hit_sleep = (avs_address_in == `CG_OFS_SLEEP_GATE);
    assign hit_deep = (avs_address_in == `CG_OFS_DEEP_GATE);
    assign hit_stat = (avs_address_in == `CG_OFS_IRQ_STATUS);
    assign hit_mask = (avs_address_in == `CG_OFS_IRQ_MASK);
    assign hit_appl = (avs_address_in == `CG_OFS_APPLIED);
    assign hit_any = hit_cfg | hit_run | hit_sleep | hit_deep |
        hit_stat | hit_mask | hit_appl;

    // ------------------------------------------------------------
    // gate and configuration registers
    // ------------------------------------------------------------
    wire [31:0] run_gate_q;
    wire [31:0] sleep_gate_q;
    wire [31:0] deep_gate_q;
    wire [31:0] cfg_q;
    wire [31:0] irq_mask_q;

    // run-mode enables
    gate_reg_word #(
        .WR_MASK(`CG_GATE_WR_MASK),
        .RESET_VALUE(`CG_GATE_RESET)
    ) run_gate_reg (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .wr_in(wr_stb & hit_run),
        .data_in(avs_writedata_in),
        .be_in(avs_byteenable_in),
        .q_out(run_gate_q)
    );

    // sleep-mode enables
    gate_reg_word #(
        .WR_MASK(`CG_GATE_WR_MASK),
        .RESET_VALUE(`CG_GATE_RESET)
    ) sleep_gate_reg (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .wr_in(wr_stb & hit_sleep),
        .data_in(avs_writedata_in),
        .be_in(avs_byteenable_in),
        .q_out(sleep_gate_q)
    );

    // deep-sleep enables; reserved bits forced to zero by the mask
    gate_reg_word #(
        .WR_MASK(`CG_GATE_WR_MASK),
        .RESET_VALUE(`CG_GATE_RESET)
    ) deep_gate_reg (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .wr_in(wr_stb & hit_deep),
        .data_in(avs_writedata_in),
        .be_in(avs_byteenable_in),
        .q_out(deep_gate_q)
    );

    // run clock configuration, only the auto gating bit is held here
    gate_reg_word #(
        .WR_MASK(`CG_CFG_WR_MASK),
        .RESET_VALUE(32'h00000000)
    ) cfg_reg (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .wr_in(wr_stb & hit_cfg),
        .data_in(avs_writedata_in),
        .be_in(avs_byteenable_in),
        .q_out(cfg_q)
    );

    // interrupt mask, same layout as the status
    gate_reg_word #(
        .WR_MASK(`CG_IRQ_WR_MASK),
        .RESET_VALUE(32'h00000000)
    ) irq_mask_reg (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .wr_in(wr_stb & hit_mask),
        .data_in(avs_writedata_in),
        .be_in(avs_byteenable_in),
        .q_out(irq_mask_q)
    );

    // ------------------------------------------------------------
    // enable selection by power state
    // ------------------------------------------------------------
    wire auto_gate;
    reg [31:0] sel_gate;
    reg [8:0] enable_q;
    reg [8:0] enable_d;

    assign auto_gate = cfg_q[`CG_AUTO_GATE_BIT];

    localparam [2:0] SEL_RUN = 3'b001;
    localparam [2:0] SEL_SLEEP = 3'b010;
    localparam [2:0] SEL_DEEP = 3'b100;
    reg [2:0] sel_code;

    // deep sleep wins over sleep; without auto gating run applies
    always @* begin
        if (auto_gate && deep_sleep_in) begin
            sel_code = SEL_DEEP;
        end else if (auto_gate && sleep_in) begin
            sel_code = SEL_SLEEP;
        end else begin
            sel_code = SEL_RUN;
        end
    end

    // one-hot pick of the gate word applied now
    always @* begin
        case (sel_code)
            SEL_DEEP: begin
                sel_gate = deep_gate_q;
            end
            SEL_SLEEP: begin
                sel_gate = sleep_gate_q;
            end
            default: begin
                sel_gate = run_gate_q;
            end
        endcase
    end

    // compress the register layout onto unit order
    always @* begin
        enable_d[6:0] = sel_gate[`CG_PORT_MSB:`CG_PORT_LSB];
        enable_d[7] = sel_gate[`CG_MAC_BIT];
        enable_d[8] = sel_gate[`CG_PHY_BIT];
    end

    // registered enables for the unit clock gates, all off after reset
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_q <= 9'h000;
        end else if (ce_in) begin
            enable_q <= enable_d;
        end
    end

    // the units stay unclocked until software enables them
    assign unit_clock_enable_out = enable_q;

    // ------------------------------------------------------------
    // access guards
    // ------------------------------------------------------------
    genvar g;

    generate
        for (g = 0; g < `CG_UNITS; g = g + 1) begin : guard
            unit_access_guard guard_inst (
                .ref_clk_in(ref_clk_in),
                .rst_n_in(rst_n_in),
                .ce_in(ce_in),
                .access_in(unit_access_in[g]),
                .clock_enable_in(enable_q[g]),
                .fault_out(unit_fault_out[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------
    reg sleep_prev_q;
    reg deep_prev_q;
    reg [2:0] irq_stat_q;
    wire [2:0] evt;
    wire [2:0] clr;

    // previous power state for entry detection
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sleep_prev_q <= 1'b0;
            deep_prev_q <= 1'b0;
        end else if (ce_in) begin
            sleep_prev_q <= sleep_in;
            deep_prev_q <= deep_sleep_in;
        end
    end

    assign evt[`CG_EVT_FAULT] = |unit_fault_out;
    assign evt[`CG_EVT_SLEEP] = sleep_in & ~sleep_prev_q;
    assign evt[`CG_EVT_DEEP] = deep_sleep_in & ~deep_prev_q;
    assign clr = (wr_stb & hit_stat & avs_byteenable_in[0]) ?
        avs_writedata_in[2:0] : 3'h0;

    // sticky status, write one clears, a new event beats the clear
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_stat_q <= 3'h0;
        end else if (ce_in) begin
            irq_stat_q <= (irq_stat_q & ~clr) | evt;
        end
    end

    assign irq_out = |(irq_stat_q & irq_mask_q[2:0]);

    // ------------------------------------------------------------
    // read data and response
    // ------------------------------------------------------------
    reg [31:0] rd_mux;

    // read path; reserved bits come back as zero
    always @* begin
        rd_mux = 32'h00000000;
        if (hit_cfg) begin
            rd_mux = cfg_q;
        end else if (hit_run) begin
            rd_mux = run_gate_q;
        end else if (hit_sleep) begin
            rd_mux = sleep_gate_q;
        end else if (hit_deep) begin
            rd_mux = deep_gate_q & `CG_GATE_WR_MASK;
        end else if (hit_stat) begin
            rd_mux[2:0] = irq_stat_q;
        end else if (hit_mask) begin
            rd_mux = irq_mask_q;
        end else if (hit_appl) begin
            rd_mux[`CG_PORT_MSB:`CG_PORT_LSB] = enable_q[6:0];
            rd_mux[`CG_MAC_BIT] = enable_q[7];
            rd_mux[`CG_PHY_BIT] = enable_q[8];
            rd_mux[`CG_MODE_SLEEP_BIT] = sleep_in;
            rd_mux[`CG_MODE_DEEP_BIT] = deep_sleep_in;
        end
    end

    // answer is captured in the wait cycle and stands when taken
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= 32'h00000000;
            resp_q <= `CG_RESP_OKAY;
        end else if (ce_in && req && !ack) begin
            rdata_q <= avs_read_in ? rd_mux : 32'h00000000;
            resp_q <= hit_any ? `CG_RESP_OKAY : `CG_RESP_SLVERR;
        end
    end

    assign avs_readdata_out = rdata_q;
    assign avs_response_out = resp_q;

endmodule // deep_sleep_clock_gate_bank

// ===== testbench/deep_sleep_clock_gate_bank_chk.sv
// checker for the clock gate bank, watching the top-level ports only
// assumes one clock domain and the header of the gate map on the path
`timescale 1ns/1ps
`include "clock_gate_map.vh"
module deep_sleep_clock_gate_bank_chk (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire ce_in,
    input wire [11:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    input wire avs_waitrequest_out,
    input wire [31:0] avs_readdata_out,
    input wire [1:0] avs_response_out,
    input wire sleep_in,
    input wire deep_sleep_in,
    input wire [8:0] unit_access_in,
    input wire [8:0] unit_fault_out,
    input wire [8:0] unit_clock_enable_out,
    input wire irq_out
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    wire rd_ack;
    wire [1:0] pw;
    assign rd_ack = avs_read_in && !avs_waitrequest_out;
    assign pw = {sleep_in, deep_sleep_in};
    default clocking dc @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_RST_CLEAR: assert property (
        $rose(rst_n_in) |-> unit_clock_enable_out == 9'h000 && !irq_out)
        else $error("enables or irq set after reset");
    AST_WAIT_ONE: assert property (
        $rose(avs_read_in || avs_write_in) |->
        avs_waitrequest_out ##1 (!avs_waitrequest_out || !ce_in))
        else $error("access not answered after one wait cycle");
    AST_NO_STALL_IDLE: assert property (
        !(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
        else $error("waitrequest high without a request");
    AST_FAULT: assert property (
        ce_in |=> unit_fault_out ==
        $past(unit_access_in & ~unit_clock_enable_out))
        else $error("unit fault does not follow gated access");
    AST_RESV_ZERO: assert property (
        rd_ack && avs_address_in inside {`CG_OFS_RUN_GATE,
        `CG_OFS_SLEEP_GATE, `CG_OFS_DEEP_GATE} |->
        (avs_readdata_out & 32'hafffff80) == 32'h00000000)
        else $error("reserved gate bits read nonzero");
    AST_DEEP_OKAY: assert property (
        rd_ack && avs_address_in == `CG_OFS_DEEP_GATE |->
        avs_response_out == `CG_RESP_OKAY)
        else $error("deep gate read not answered okay");
    AST_UNMAPPED: assert property (
        rd_ack && !(avs_address_in inside {`CG_OFS_RUN_CFG,
        `CG_OFS_RUN_GATE, `CG_OFS_SLEEP_GATE, `CG_OFS_DEEP_GATE,
        `CG_OFS_IRQ_STATUS, `CG_OFS_IRQ_MASK, `CG_OFS_APPLIED}) |->
        avs_response_out == `CG_RESP_SLVERR && avs_readdata_out == 32'h0)
        else $error("unmapped read not refused");
    AST_EN_HOLD: assert property (
        ce_in && $past(ce_in) && $past(ce_in, 2) &&
        !avs_write_in && !$past(avs_write_in) &&
        !$past(avs_write_in, 2) && $stable(pw) && $past(pw) == $past(pw, 2)
        && $past(pw, 2) == $past(pw, 3) |-> $stable(unit_clock_enable_out))
        else $error("enables changed without a cause");
endmodule // deep_sleep_clock_gate_bank_chk

bind deep_sleep_clock_gate_bank deep_sleep_clock_gate_bank_chk u_chk (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_waitrequest_out(avs_waitrequest_out),
    .avs_readdata_out(avs_readdata_out),
    .avs_response_out(avs_response_out), .sleep_in(sleep_in),
    .deep_sleep_in(deep_sleep_in), .unit_access_in(unit_access_in),
    .unit_fault_out(unit_fault_out),
    .unit_clock_enable_out(unit_clock_enable_out), .irq_out(irq_out));

// ===== testbench/test_deep_sleep_clock_gate_bank.sv
// self-checking bench for the clock gate bank over avalon-mm
// assumes the bank answers each access after its own wait cycles
`timescale 1ns/1ps
`include "clock_gate_map.vh"
module test_deep_sleep_clock_gate_bank;
    reg ref_clk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg ce_in = 1'b1;
    reg [11:0] avs_address_in = 12'h000;
    reg avs_read_in = 1'b0;
    reg avs_write_in = 1'b0;
    reg [31:0] avs_writedata_in = 32'h0;
    reg [3:0] avs_byteenable_in = 4'hf;
    reg sleep_in = 1'b0;
    reg deep_sleep_in = 1'b0;
    reg [8:0] unit_access_in = 9'h000;
    wire avs_waitrequest_out;
    wire [31:0] avs_readdata_out;
    wire [1:0] avs_response_out;
    wire [8:0] unit_fault_out;
    wire [8:0] unit_clock_enable_out;
    wire irq_out;
    integer err_total = 0;
    integer num_checks = 0;
    integer i;
    integer m;
    reg [31:0] g;
    reg [1:0] rs;
    reg [31:0] regs [0:2];

    deep_sleep_clock_gate_bank u_dut (.ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in), .ce_in(ce_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in),
        .avs_waitrequest_out(avs_waitrequest_out),
        .avs_readdata_out(avs_readdata_out),
        .avs_response_out(avs_response_out), .sleep_in(sleep_in),
        .deep_sleep_in(deep_sleep_in), .unit_access_in(unit_access_in),
        .unit_fault_out(unit_fault_out),
        .unit_clock_enable_out(unit_clock_enable_out), .irq_out(irq_out));

    // 40 mhz clock
    always #12.5 ref_clk_in = ~ref_clk_in;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
            end
        end
    endtask
    // one access, held until waitrequest is seen low
    task bus(input w, input [11:0] a, input [31:0] d, input [3:0] b);
        begin
            @(posedge ref_clk_in);
            avs_address_in <= a;
            avs_writedata_in <= d;
            avs_byteenable_in <= b;
            avs_read_in <= ~w;
            avs_write_in <= w;
            @(posedge ref_clk_in);
            while (avs_waitrequest_out !== 1'b0) @(posedge ref_clk_in);
            g = avs_readdata_out;
            rs = avs_response_out;
            avs_read_in <= 1'b0;
            avs_write_in <= 1'b0;
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task rd(input [11:0] a, input [31:0] d, input [1:0] r);
        begin
            bus(1'b0, a, 32'h0, 4'hf);
            chk(g, d);
            chk({30'h0, rs}, {30'h0, r});
        end
    endtask
    // set the power state and let the applied enables settle
    task mode(input s, input d);
        begin
            @(posedge ref_clk_in);
            sleep_in <= s;
            deep_sleep_in <= d;
            repeat (3) @(posedge ref_clk_in);
            @(negedge ref_clk_in);
        end
    endtask
    task rst;
        begin
            @(posedge ref_clk_in);
            rst_n_in <= 1'b0;
            repeat (3) @(posedge ref_clk_in);
            @(negedge ref_clk_in);
            chk({23'h0, unit_clock_enable_out}, 32'h0);
            chk({31'h0, irq_out}, 32'h0);
            @(posedge ref_clk_in);
            rst_n_in <= 1'b1;
        end
    endtask
    // gate word to unit order: ports a..g, mac, phy
    function [31:0] en(input [31:0] w);
        en = {23'h0, w[30], w[28], w[6:0]};
    endfunction
    task results;
        begin
            $display("checks %0d errors %0d", num_checks, err_total);
            if (err_total == 0 && num_checks > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        rst;
        rd(`CG_OFS_DEEP_GATE, 32'h0, `CG_RESP_OKAY);
        wr(`CG_OFS_DEEP_GATE, 32'hffffffff);
        rd(`CG_OFS_DEEP_GATE, 32'h5000007f, `CG_RESP_OKAY);
        bus(1'b1, `CG_OFS_DEEP_GATE, 32'h0, 4'he);
        rd(`CG_OFS_DEEP_GATE, 32'h0000007f, `CG_RESP_OKAY);
        regs[0] = 32'h50000041;
        regs[1] = 32'h10000002;
        regs[2] = 32'h40000004;
        wr(`CG_OFS_RUN_GATE, regs[0]);
        wr(`CG_OFS_SLEEP_GATE, regs[1]);
        wr(`CG_OFS_DEEP_GATE, regs[2]);
        rd(`CG_OFS_SLEEP_GATE, regs[1], `CG_RESP_OKAY);
        // run, sleep, deep without and then with automatic gating
        for (m = 0; m < 6; m = m + 1) begin
            if (m == 3) wr(`CG_OFS_RUN_CFG, 32'h08000000);
            mode(m % 3 == 1, m % 3 == 2);
            g = en(regs[m < 3 ? 0 : m % 3]);
            chk({23'h0, unit_clock_enable_out}, g);
        end
        // one enable at a time in deep sleep
        for (i = 0; i < 9; i = i + 1) begin
            wr(`CG_OFS_DEEP_GATE, 32'h1 << (i < 7 ? i : (i == 7 ? 28 : 30)));
            mode(1'b0, 1'b1);
            chk({23'h0, unit_clock_enable_out}, 32'h1 << i);
        end
        // access every unit while only the phy is clocked
        @(posedge ref_clk_in);
        unit_access_in <= 9'h1ff;
        @(posedge ref_clk_in);
        unit_access_in <= 9'h000;
        @(negedge ref_clk_in);
        chk({23'h0, unit_fault_out}, 32'h000000ff);
        wr(`CG_OFS_IRQ_MASK, 32'h7);
        mode(1'b0, 1'b1);
        chk({31'h0, irq_out}, 32'h1);
        rd(`CG_OFS_IRQ_STATUS, 32'h7, `CG_RESP_OKAY);
        wr(`CG_OFS_IRQ_STATUS, 32'h7);
        mode(1'b0, 1'b1);
        chk({31'h0, irq_out}, 32'h0);
        rd(`CG_OFS_IRQ_MASK, 32'h7, `CG_RESP_OKAY);
        rd(12'h004, 32'h0, `CG_RESP_SLVERR);
        rd(`CG_OFS_APPLIED, 32'h40020000, `CG_RESP_OKAY);
        // a low clock enable freezes the applied enables
        @(posedge ref_clk_in);
        ce_in <= 1'b0;
        mode(1'b0, 1'b0);
        chk({23'h0, unit_clock_enable_out}, 32'h100);
        @(posedge ref_clk_in);
        ce_in <= 1'b1;
        mode(1'b0, 1'b0);
        chk({23'h0, unit_clock_enable_out}, en(regs[0]));
        rst;
        rd(`CG_OFS_DEEP_GATE, 32'h0, `CG_RESP_OKAY);
        results;
    end

    // watchdog against a hung access
    initial begin
        #200000;
        err_total = err_total + 1;
        results;
    end
endmodule // test_deep_sleep_clock_gate_bank
